// [src/sqrs_consts.svh]
// Timing constants for the squib reset supervisor
// Assumes a 200 MHz core clock
`ifndef SQRS_CONSTS_SVH
`define SQRS_CONSTS_SVH
`define SQRS_CLK_PERIOD_NS 5
`define SQRS_DEGLITCH_NS 1000
`define SQRS_DEGLITCH_CYC ((`SQRS_DEGLITCH_NS + `SQRS_CLK_PERIOD_NS - 1) / `SQRS_CLK_PERIOD_NS)
`define SQRS_UV_FILTER_NS 5000
`define SQRS_UV_FILTER_CYC ((`SQRS_UV_FILTER_NS + `SQRS_CLK_PERIOD_NS - 1) / `SQRS_CLK_PERIOD_NS)
`define SQRS_NUM_CH 4
`define SQRS_CNT_W 16
`endif

// [src/sqrs_pkg.sv]
// Types for the squib reset supervisor
// Used by the top module and the testbench
package sqrs_pkg;
  typedef enum logic [1:0] {
    SQRS_RUN,
    SQRS_HOLD,
    SQRS_RESET
  } sqrs_state_t;
endpackage

// [src/sqrs_filter.sv]
// Persistence filter: output goes high only after input held high N cycles
// Input assumed synchronous to core_clk
`timescale 1ns/10ps
module sqrs_filter #(
  parameter int CYCLES = 200,
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_active,
  output logic out_active
);
  logic [CW-1:0] count;

  initial begin
    if (CYCLES < 1 || CYCLES >= (1 << CW)) begin
      $error("sqrs_filter: CYCLES out of range");
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!in_active) begin
      count <= '0;
    end else if (count != CW'(CYCLES)) begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_active <= 1'b0;
    end else begin
      out_active <= in_active && (count >= CW'(CYCLES - 1));
    end
  end
endmodule

// [src/sqrs_top.sv]
// Reset supervisor for a four-loop squib driver
// Detector inputs come from analogue comparators, synchronous to core_clk
// Function
// R1 - Filtered undervoltage held for filter time resets device, outputs off
// R2 - Unfiltered lower undervoltage resets device immediately
// R3 - Deglitched external reset low outside deployment resets device
// R4 - External reset ignored while any deployment runs
// R5 - Undervoltage resets even during deployment
// R6 - External reset still low at deployment end then resets
// R7 - External reset pulses shorter than deglitch time ignored
// R8 - Bias resistor out of limits resets device
// R9 - Logic ground loss resets device
// R10 - Channel power ground loss disables only that low-side driver
// R11 - Open power ground on one channel leaves others unchanged
// R12 - Open power ground reported via low-side diagnostic result
// R13 - Analogue ground loss pulls monitor high and resets device
// R14 - Four loops, per-channel ground effects kept separately
// R15 - Sources combined into one reset; drivers off same cycle
`timescale 1ns/10ps
`include "sqrs_consts.svh"
module sqrs_top #(
  parameter int NUM_CH = `SQRS_NUM_CH,
  parameter int DEGLITCH_CYC = `SQRS_DEGLITCH_CYC,
  parameter int UV_FILTER_CYC = `SQRS_UV_FILTER_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic filtered_undervolt_threshold,
  input wire logic unfiltered_undervolt_threshold,
  input wire logic ext_reset_n,
  input wire logic bias_resistor_upper_limit,
  input wire logic bias_resistor_lower_limit,
  input wire logic logic_ground_lost,
  input wire logic analog_ground_lost,
  input wire logic [NUM_CH-1:0] channel_power_ground,
  input wire logic [NUM_CH-1:0] deploy_active,
  input wire logic [NUM_CH-1:0] high_side_req,
  input wire logic [NUM_CH-1:0] low_side_req,
  input wire logic [NUM_CH-1:0] ls_diag_req,
  output logic [NUM_CH-1:0] squib_high_side_output,
  output logic [NUM_CH-1:0] squib_low_side_output,
  output logic [NUM_CH-1:0] ls_diag_fail,
  output logic analog_monitor_force_high,
  output logic core_reset_n,
  output sqrs_pkg::sqrs_state_t reset_state
);
  initial begin
    if (NUM_CH != 4 || DEGLITCH_CYC < 1 || UV_FILTER_CYC < 1) begin
      $error("sqrs_top: unsupported parameter values");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  logic uv_filt;
  logic ext_filt;
  logic deploying;
  logic hard_reset;
  logic reset_now;
  sqrs_pkg::sqrs_state_t next_state;

  // R1 filtered undervoltage
  sqrs_filter #(.CYCLES(UV_FILTER_CYC), .CW(`SQRS_CNT_W)) u_uv_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_active(filtered_undervolt_threshold),
    .out_active(uv_filt)
  );

  // R7 deglitch external reset
  sqrs_filter #(.CYCLES(DEGLITCH_CYC), .CW(`SQRS_CNT_W)) u_ext_filter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_active(!ext_reset_n),
    .out_active(ext_filt)
  );

  assign deploying = |deploy_active;

  // R2 R5 R8 R9 R13 unconditional sources
  assign hard_reset = uv_filt || unfiltered_undervolt_threshold || bias_resistor_upper_limit
    || bias_resistor_lower_limit || logic_ground_lost || analog_ground_lost;

  // R3 R4 R6 external reset gated by deployment
  assign reset_now = hard_reset || (ext_filt && !deploying);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (reset_state)
      sqrs_pkg::SQRS_RUN: begin
        if (reset_now) begin
          next_state = sqrs_pkg::SQRS_RESET;
        end else if (ext_filt) begin
          next_state = sqrs_pkg::SQRS_HOLD;
        end else begin
          next_state = sqrs_pkg::SQRS_RUN;
        end
      end
      sqrs_pkg::SQRS_HOLD: begin
        if (reset_now) begin
          next_state = sqrs_pkg::SQRS_RESET;
        end else if (!ext_filt) begin
          next_state = sqrs_pkg::SQRS_RUN;
        end else begin
          next_state = sqrs_pkg::SQRS_HOLD;
        end
      end
      sqrs_pkg::SQRS_RESET: begin
        next_state = reset_now ? sqrs_pkg::SQRS_RESET : sqrs_pkg::SQRS_RUN;
      end
      default: begin
        next_state = sqrs_pkg::SQRS_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_state <= sqrs_pkg::SQRS_RESET;
    end else begin
      reset_state <= next_state;
    end
  end

  // R15 single internal reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= !reset_now;
    end
  end

  // R13 monitor pulled to supply
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_monitor_force_high <= 1'b0;
    end else begin
      analog_monitor_force_high <= analog_ground_lost;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Driver gating is per channel so one open ground cannot leak across
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      // R14 per-channel drivers
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          squib_high_side_output[ch] <= 1'b0;
          squib_low_side_output[ch] <= 1'b0;
          ls_diag_fail[ch] <= 1'b0;
        end else if (reset_now) begin
          // R15 drivers off with reset
          squib_high_side_output[ch] <= 1'b0;
          squib_low_side_output[ch] <= 1'b0;
          ls_diag_fail[ch] <= 1'b0;
        end else begin
          // R10 R11 high side unaffected by ground loss
          squib_high_side_output[ch] <= high_side_req[ch];
          // R10 low side blocked on open ground
          squib_low_side_output[ch] <= (low_side_req[ch] || ls_diag_req[ch]) && !channel_power_ground[ch];
          // R12 ground loss shown by diagnostic
          ls_diag_fail[ch] <= ls_diag_req[ch] && channel_power_ground[ch];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // R2 immediate reset
  property p_uv2_reset;
    @(posedge core_clk) disable iff (!rst_n)
      unfiltered_undervolt_threshold |=> (!core_reset_n && squib_high_side_output == '0);
  endproperty
  a_uv2_reset: assert property (p_uv2_reset) else $error("unfiltered undervoltage did not reset"); // R2

  property p_ext_ignored;
    @(posedge core_clk) disable iff (!rst_n)
      (deploying && !hard_reset) |=> core_reset_n;
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("reset during deployment without cause"); // R4

  property p_uv_in_deploy;
    @(posedge core_clk) disable iff (!rst_n)
      (deploying && uv_filt) |=> !core_reset_n;
  endproperty
  a_uv_in_deploy: assert property (p_uv_in_deploy) else $error("undervoltage held off by deployment"); // R5

  property p_ext_after;
    @(posedge core_clk) disable iff (!rst_n)
      (ext_filt && $fell(deploying)) |=> !core_reset_n;
  endproperty
  a_ext_after: assert property (p_ext_after) else $error("pending external reset not applied"); // R6

  property p_glitch;
    @(posedge core_clk) disable iff (!rst_n)
      ($fell(ext_reset_n) ##1 ext_reset_n) |-> !ext_filt;
  endproperty
  a_glitch: assert property (p_glitch) else $error("short external reset accepted"); // R7

  property p_bias;
    @(posedge core_clk) disable iff (!rst_n)
      (bias_resistor_upper_limit || bias_resistor_lower_limit) |=> !core_reset_n;
  endproperty
  a_bias: assert property (p_bias) else $error("bias resistor fault did not reset"); // R8

  property p_gnd;
    @(posedge core_clk) disable iff (!rst_n)
      logic_ground_lost |=> (!core_reset_n && squib_low_side_output == '0);
  endproperty
  a_gnd: assert property (p_gnd) else $error("logic ground loss did not reset"); // R9

  property p_ls_gnd;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (squib_low_side_output & $past(channel_power_ground)) == '0;
  endproperty
  a_ls_gnd: assert property (p_ls_gnd) else $error("low side on with open ground"); // R10

  property p_analog_ground_ref;
    @(posedge core_clk) disable iff (!rst_n)
      analog_ground_lost |=> (analog_monitor_force_high && !core_reset_n);
  endproperty
  a_analog_ground_ref: assert property (p_analog_ground_ref) else $error("analogue ground loss not handled"); // R13
endmodule

// [sim/sqrs_host.sv]
// Host model that drives the external reset pin
// Assumes calls start just after a core_clk rising edge
`timescale 1ns/10ps
module sqrs_host (
  input wire logic core_clk,
  output logic ext_reset_n
);
  // Pin idles high through its pull-up
  initial ext_reset_n = 1'b1;
  task automatic hold_low(input int n);
    ext_reset_n = 1'b0;
    repeat (n) @(posedge core_clk);
    #1 ext_reset_n = 1'b1;
  endtask
  task automatic drive(input logic lvl);
    ext_reset_n = lvl;
  endtask
endmodule

// [sim/sqrs_top_tb.sv]
// Self-checking bench for the squib reset supervisor
// Assumes short filter counts: deglitch 3, undervoltage 4
`timescale 1ns/10ps
module sqrs_top_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic uvf = 1'b0;
  logic [4:0] src = 5'h0;
  logic [3:0] pgnd = 4'h0;
  logic [3:0] dep = 4'h0;
  logic [3:0] hs = 4'h0;
  logic [3:0] ls = 4'h0;
  logic [3:0] dg = 4'h0;
  logic [31:0] r;
  logic ext_reset_n;
  logic [3:0] hs_o, ls_o, fail_o;
  logic mon, core_reset_n;
  sqrs_pkg::sqrs_state_t st;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  sqrs_host sqrs_host_i (.core_clk(core_clk), .ext_reset_n(ext_reset_n));
  sqrs_top #(.DEGLITCH_CYC(3), .UV_FILTER_CYC(4)) sqrs_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .filtered_undervolt_threshold(uvf),
    .unfiltered_undervolt_threshold(src[0]), .ext_reset_n(ext_reset_n),
    .bias_resistor_upper_limit(src[1]), .bias_resistor_lower_limit(src[2]),
    .logic_ground_lost(src[3]), .analog_ground_lost(src[4]), .channel_power_ground(pgnd),
    .deploy_active(dep), .high_side_req(hs), .low_side_req(ls), .ls_diag_req(dg),
    .squib_high_side_output(hs_o), .squib_low_side_output(ls_o), .ls_diag_fail(fail_o),
    .analog_monitor_force_high(mon), .core_reset_n(core_reset_n), .reset_state(st));
  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait, so a stuck reset shows as one mismatch
  task automatic wait_rst(input logic lvl, input int max);
    for (int i = 0; i < max && core_reset_n !== lvl; i++) step(1);
    chk({7'h0, core_reset_n}, {7'h0, lvl});
  endtask
  task automatic stay_up(input int n);
    repeat (n) begin
      step(1);
      chk({7'h0, core_reset_n}, 8'h1);
    end
  endtask
  function automatic logic [3:0] exp_ls(input logic [3:0] q, d, g);
    return (q | d) & ~g;
  endfunction
  task automatic final_report();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h73183de2));
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    step(2);
    for (int k = 0; k < 24; k++) begin
      r = $urandom;
      {hs, ls, dg, pgnd} = (k == 0) ? 16'hffff : r[15:0];
      dep = r[19:16];
      // Blips of two cycles at most, too short to trip the filter
      uvf = r[20] && (k % 2 == 0);
      step(2);
      chk({4'h0, hs_o}, {4'h0, hs});
      chk({4'h0, ls_o}, {4'h0, exp_ls(ls, dg, pgnd)});
      chk({4'h0, fail_o}, {4'h0, dg & pgnd});
    end
    $display("channel test done");
    uvf = 1'b0;
    hs = 4'hf;
    for (int s = 0; s < 5; s++) begin
      dep = 4'hf;
      src = 5'h1 << s;
      step(1);
      chk({3'h0, core_reset_n, hs_o}, 8'h0);
      chk({6'h0, st}, {6'h0, sqrs_pkg::SQRS_RESET});
      chk({7'h0, mon}, {7'h0, s == 4});
      src = 5'h0;
      dep = 4'h0;
      wait_rst(1'b1, 4);
    end
    $display("hard source test done");
    uvf = 1'b1;
    step(3);
    uvf = 1'b0;
    stay_up(6);
    uvf = 1'b1;
    dep = 4'h2;
    wait_rst(1'b0, 8);
    uvf = 1'b0;
    dep = 4'h0;
    wait_rst(1'b1, 4);
    $display("undervoltage test done");
    sqrs_host_i.hold_low(1);
    stay_up(3);
    sqrs_host_i.hold_low(2);
    stay_up(6);
    sqrs_host_i.drive(1'b0);
    wait_rst(1'b0, 8);
    chk({4'h0, hs_o}, 8'h0);
    sqrs_host_i.drive(1'b1);
    wait_rst(1'b1, 5);
    dep = 4'h8;
    sqrs_host_i.drive(1'b0);
    stay_up(8);
    chk({6'h0, st}, {6'h0, sqrs_pkg::SQRS_HOLD});
    dep = 4'h0;
    wait_rst(1'b0, 4);
    sqrs_host_i.drive(1'b1);
    wait_rst(1'b1, 5);
    // Pending reset withdrawn before the deployment ends
    dep = 4'h1;
    sqrs_host_i.drive(1'b0);
    stay_up(5);
    sqrs_host_i.drive(1'b1);
    stay_up(4);
    chk({6'h0, st}, {6'h0, sqrs_pkg::SQRS_RUN});
    dep = 4'h0;
    $display("external reset test done");
    final_report();
  end
endmodule
